// File: llc_prot_consts.svh
// register map, field positions, reset values and timing counts of the protection supervisor
`ifndef LLC_PROT_CONSTS_SVH
`define LLC_PROT_CONSTS_SVH

// clock and the microsecond tick that paces all timers
`define CLK_PERIOD_NS   25
`define TICK_NS         1000
`define TICK_CYC        (`TICK_NS / `CLK_PERIOD_NS)
`define TICK_W          6

// register byte addresses
`define ADDR_CTRL       8'h00
`define ADDR_OPP_FILT   8'h04
`define ADDR_SC_CFG     8'h08
`define ADDR_RESTART    8'h0c
`define ADDR_STATUS     8'h10
`define ADDR_MASK       8'h14
`define ADDR_STATE      8'h18

// control fields
`define CTRL_W          8
`define CTRL_XCAP       0
`define CTRL_OPP_LSB    1
`define CTRL_SCP_LSB    3
`define CTRL_CMR_LSB    5
`define SC_TRIP_LSB     0
`define SC_CLEAR_LSB    8

// status bits
`define ST_W            4
`define ST_OPP          0
`define ST_OCP          1
`define ST_SCP          2
`define ST_CMR          3

// response codes of a protection
`define RESP_RETRY      2'h0
`define RESP_HICCUP     2'h1
`define RESP_LATCH_BIT  1
`define HICCUP_SHIFT    3
`define RESTART_CW      19

// reset values
`define CTRL_RST        8'h21
`define OPP_FILT_RST    16'h03e8
`define SC_CFG_RST      16'h1008
`define RESTART_RST     16'h2710

`endif

// File: llc_prot_pkg.sv
// types shared by the protection supervisor modules
package llc_prot_pkg;

    // operating mode reported by the modulator
    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_SKIP1,
        MODE_SKIP2,
        MODE_BURST
    } ctrl_mode_t;

    // stop-and-restart sequencer states
    typedef enum logic [1:0] {
        RS_RUN,
        RS_WAIT,
        RS_LATCHED
    } resp_state_t;

endpackage

// File: input_sync.sv
// two-flop synchroniser for comparator and pin inputs
`timescale 1ns/100ps

module input_sync #(
    parameter int W = 1
) (
    input  wire logic         i_core_clk,
    input  wire logic         i_resetn,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    // first stage feeds only the second stage
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            meta_reg <= '0;
            q_reg    <= '0;
        end else begin
            meta_reg <= i_d;
            q_reg    <= meta_reg;
        end
    end

    assign o_q = q_reg;

endmodule

// File: restart_ctrl.sv
// stop, wait and restart sequencer of one protection (retry, hiccup or latch)
`timescale 1ns/100ps
`include "llc_prot_consts.svh"

module restart_ctrl (
    input  wire logic        i_core_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_tick,
    input  wire logic        i_fault,
    input  wire logic [1:0]  i_resp,
    input  wire logic [15:0] i_interval,
    output logic             o_stopped,
    output logic             o_latched
);

    llc_prot_pkg::resp_state_t       state_reg;
    llc_prot_pkg::resp_state_t       state_next;
    logic [`RESTART_CW-1:0]          cnt_reg;
    logic [`RESTART_CW-1:0]          cnt_next;
    logic [`RESTART_CW-1:0]          load_val;

    // hiccup waits a longer multiple of the interval than retry
    assign load_val = (i_resp == `RESP_HICCUP) ?
                      ({3'h0, i_interval} << `HICCUP_SHIFT) : {3'h0, i_interval};

    // next state; a fault while already waiting does not stretch the wait
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        case (state_reg)
            llc_prot_pkg::RS_RUN: begin
                if (i_fault) begin
                    if (i_resp[`RESP_LATCH_BIT]) begin
                        state_next = llc_prot_pkg::RS_LATCHED;
                    end else begin
                        state_next = llc_prot_pkg::RS_WAIT;
                        cnt_next   = load_val;
                    end
                end
            end
            llc_prot_pkg::RS_WAIT: begin
                if (i_tick) begin
                    if (cnt_reg <= `RESTART_CW'(1)) begin
                        state_next = llc_prot_pkg::RS_RUN;
                    end else begin
                        cnt_next = cnt_reg - `RESTART_CW'(1);
                    end
                end
            end
            llc_prot_pkg::RS_LATCHED: begin
                state_next = llc_prot_pkg::RS_LATCHED;
            end
            default: begin
                state_next = llc_prot_pkg::RS_RUN;
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            state_reg <= llc_prot_pkg::RS_RUN;
            cnt_reg   <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    assign o_stopped = (state_reg != llc_prot_pkg::RS_RUN);
    assign o_latched = (state_reg == llc_prot_pkg::RS_LATCHED);

endmodule

// File: llc_protection_supervisor.sv
// protection supervisor: overpower, overcurrent, short circuit, capacitive mode, standby output
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/100ps
`include "llc_prot_consts.svh"

module llc_protection_supervisor (
    input  wire logic                     i_core_clk,
    input  wire logic                     i_resetn,
    input  wire logic                     i_psel,
    input  wire logic                     i_penable,
    input  wire logic                     i_pwrite,
    input  wire logic [7:0]               i_paddr,
    input  wire logic [31:0]              i_pwdata,
    output logic      [31:0]              o_prdata,
    output logic                          o_pready,
    output logic                          o_pslverr,
    input  wire logic                     i_fb_low,
    input  wire logic                     i_cs_over,
    input  wire logic                     i_cmr_pos_cross,
    input  wire logic                     i_cmr_neg_cross,
    input  wire logic                     i_ac_present,
    input  wire logic                     i_cycle_end,
    input  wire logic                     i_hs_on,
    input  wire logic                     i_ls_on,
    input  wire llc_prot_pkg::ctrl_mode_t i_ctrl_mode,
    input  wire logic                     i_burst_off,
    output logic                          o_switch_en,
    output logic                          o_hs_off,
    output logic                          o_ls_off,
    output logic      [2:0]               o_cmr_level,
    output logic                          o_xcap_discharge,
    output logic                          o_gpio,
    output logic                          o_irq
);

    // synchronised comparator and pin levels
    logic [4:0]               sync_q;
    logic                     fb_low_s;
    logic                     cs_over_s;
    logic                     cmr_pos_s;
    logic                     cmr_neg_s;
    logic                     ac_s;
    // timers and counters
    logic [`TICK_W-1:0]       tick_cnt_reg;
    logic [`TICK_W-1:0]       tick_cnt_next;
    logic                     tick_reg;
    logic                     tick_next;
    logic [15:0]              opp_cnt_reg;
    logic [15:0]              opp_cnt_next;
    logic                     ocp_cyc_reg;
    logic                     ocp_cyc_next;
    logic [7:0]               sc_cnt_reg;
    logic [7:0]               sc_cnt_next;
    logic [7:0]               clean_reg;
    logic [7:0]               clean_next;
    logic                     opp_evt;
    logic                     ocp_evt;
    logic                     scp_evt;
    logic                     cmr_evt;
    logic [1:0]               stopped;
    logic [1:0]               latched;
    // registers
    logic [`CTRL_W-1:0]       ctrl_reg;
    logic [`CTRL_W-1:0]       ctrl_next;
    logic [15:0]              filt_reg;
    logic [15:0]              filt_next;
    logic [15:0]              sc_cfg_reg;
    logic [15:0]              sc_cfg_next;
    logic [15:0]              restart_reg;
    logic [15:0]              restart_next;
    logic [`ST_W-1:0]         stat_reg;
    logic [`ST_W-1:0]         stat_next;
    logic [`ST_W-1:0]         mask_reg;
    logic [`ST_W-1:0]         mask_next;
    logic [31:0]              prdata_reg;
    logic [31:0]              prdata_next;
    logic                     pready_reg;
    logic                     pready_next;
    logic                     pslverr_reg;
    logic                     pslverr_next;
    logic                     wr;
    logic                     rd_cap;
    logic                     hit;
    logic [31:0]              rd_val;
    // registered outputs
    logic                     sw_en_reg;
    logic                     sw_en_next;
    logic                     hs_off_reg;
    logic                     hs_off_next;
    logic                     ls_off_reg;
    logic                     ls_off_next;
    logic                     xcap_reg;
    logic                     xcap_next;
    logic                     gpio_reg;
    logic                     gpio_next;
    logic                     irq_reg;
    logic                     irq_next;

    // comparator and mains pins cross into the core clock before any logic looks at them; driver phases, cycle end and mode are used directly
    input_sync #(
        .W (5)
    ) u_sync (
        .i_core_clk (i_core_clk),
        .i_resetn   (i_resetn),
        .i_d        ({i_ac_present, i_cmr_neg_cross, i_cmr_pos_cross, i_cs_over, i_fb_low}),
        .o_q        (sync_q)
    );
    assign {ac_s, cmr_neg_s, cmr_pos_s, cs_over_s, fb_low_s} = sync_q;

    // fault events from the current state
    // filter expiry
    assign opp_evt = fb_low_s && tick_reg && (opp_cnt_reg != filt_reg)
                     && ((opp_cnt_reg + 16'h0001) == filt_reg);
    assign ocp_evt = cs_over_s && !ocp_cyc_reg;
    assign scp_evt = sc_cnt_reg > sc_cfg_reg[`SC_TRIP_LSB +: 8];
    assign cmr_evt = (i_hs_on && cmr_pos_s) || (i_ls_on && cmr_neg_s);

    // timers and the short-circuit counters
    always_comb begin
        tick_next     = (tick_cnt_reg == `TICK_W'(`TICK_CYC - 1));
        tick_cnt_next = tick_next ? '0 : tick_cnt_reg + `TICK_W'(1);
        opp_cnt_next  = opp_cnt_reg;
        clean_next    = clean_reg;
        sc_cnt_next   = sc_cnt_reg;
        if (!fb_low_s) begin
            opp_cnt_next = '0;
        end else if (tick_reg && opp_cnt_reg != filt_reg) begin
            opp_cnt_next = opp_cnt_reg + 16'h0001;
        end
        // a trip on the cycle boundary belongs to the next cycle
        ocp_cyc_next = i_cycle_end ? ocp_evt : (ocp_cyc_reg || ocp_evt);
        if (i_cycle_end) begin
            if (ocp_cyc_reg || ocp_evt) begin
                clean_next = '0;
            end else if ((clean_reg + 8'h01) >= sc_cfg_reg[`SC_CLEAR_LSB +: 8]) begin
                clean_next  = '0;
                sc_cnt_next = '0;
            end else begin
                clean_next = clean_reg + 8'h01;
            end
        end
        if (ocp_evt && sc_cnt_reg != 8'hff) begin
            sc_cnt_next = sc_cnt_reg + 8'h01;
        end
        // a trip consumes the count so a restart starts clean
        if (scp_evt) begin
            sc_cnt_next = '0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            tick_cnt_reg <= '0;
            tick_reg     <= 1'b0;
            opp_cnt_reg  <= '0;
            ocp_cyc_reg  <= 1'b0;
            clean_reg    <= '0;
            sc_cnt_reg   <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
            tick_reg     <= tick_next;
            opp_cnt_reg  <= opp_cnt_next;
            ocp_cyc_reg  <= ocp_cyc_next;
            clean_reg    <= clean_next;
            sc_cnt_reg   <= sc_cnt_next;
        end
    end

    // one sequencer per protection: index 0 overpower, index 1 short circuit
    for (genvar g = 0; g < 2; g++) begin : g_resp
        restart_ctrl u_resp (
            .i_core_clk (i_core_clk),
            .i_resetn   (i_resetn),
            .i_tick     (tick_reg),
            .i_fault    (g == 0 ? opp_evt : scp_evt),
            .i_resp     (ctrl_reg[`CTRL_OPP_LSB + 2*g +: 2]),
            .i_interval (restart_reg),
            .o_stopped  (stopped[g]),
            .o_latched  (latched[g])
        );
    end

    // pin-side outputs, all registered
    always_comb begin
        sw_en_next  = !(|stopped) && !ocp_cyc_next;
        hs_off_next = i_hs_on && cmr_pos_s;
        ls_off_next = i_ls_on && cmr_neg_s;
        xcap_next   = ctrl_reg[`CTRL_XCAP] && !ac_s;
        gpio_next   = (i_ctrl_mode == llc_prot_pkg::MODE_BURST) && i_burst_off;
        irq_next    = |(stat_reg & mask_reg);
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            sw_en_reg  <= 1'b0;
            hs_off_reg <= 1'b0;
            ls_off_reg <= 1'b0;
            xcap_reg   <= 1'b0;
            gpio_reg   <= 1'b0;
            irq_reg    <= 1'b0;
        end else begin
            sw_en_reg  <= sw_en_next;
            hs_off_reg <= hs_off_next;
            ls_off_reg <= ls_off_next;
            xcap_reg   <= xcap_next;
            gpio_reg   <= gpio_next;
            irq_reg    <= irq_next;
        end
    end

    // apb slave: one wait state, write lands on the completing edge
    assign wr     = i_psel && i_penable && pready_reg && i_pwrite;
    assign rd_cap = i_psel && i_penable && !pready_reg;
    assign hit    = (i_paddr == `ADDR_CTRL) || (i_paddr == `ADDR_OPP_FILT)
                    || (i_paddr == `ADDR_SC_CFG) || (i_paddr == `ADDR_RESTART)
                    || (i_paddr == `ADDR_STATUS) || (i_paddr == `ADDR_MASK)
                    || (i_paddr == `ADDR_STATE);

    // read mux; unmapped addresses read zero
    always_comb begin
        case (i_paddr)
            `ADDR_CTRL:     rd_val = {24'h0, ctrl_reg};
            `ADDR_OPP_FILT: rd_val = {16'h0, filt_reg};
            `ADDR_SC_CFG:   rd_val = {16'h0, sc_cfg_reg};
            `ADDR_RESTART:  rd_val = {16'h0, restart_reg};
            `ADDR_STATUS:   rd_val = {28'h0, stat_reg};
            `ADDR_MASK:     rd_val = {28'h0, mask_reg};
            `ADDR_STATE:    rd_val = {19'h0, latched, stopped, sw_en_reg, sc_cnt_reg};
            default:        rd_val = 32'h0;
        endcase
    end

    // register writes and sticky status
    always_comb begin
        ctrl_next    = ctrl_reg;
        filt_next    = filt_reg;
        sc_cfg_next  = sc_cfg_reg;
        restart_next = restart_reg;
        mask_next    = mask_reg;
        stat_next    = stat_reg;
        pready_next  = rd_cap;
        pslverr_next = rd_cap && !hit;
        prdata_next  = rd_cap ? rd_val : prdata_reg;
        if (wr) begin
            case (i_paddr)
                `ADDR_CTRL:     ctrl_next    = i_pwdata[`CTRL_W-1:0];
                `ADDR_OPP_FILT: filt_next    = i_pwdata[15:0];
                `ADDR_SC_CFG:   sc_cfg_next  = i_pwdata[15:0];
                `ADDR_RESTART:  restart_next = i_pwdata[15:0];
                `ADDR_STATUS:   stat_next    = stat_reg & ~i_pwdata[`ST_W-1:0];
                `ADDR_MASK:     mask_next    = i_pwdata[`ST_W-1:0];
                default:        ctrl_next    = ctrl_reg;
            endcase
        end
        // sticky flags; a new event beats a same-cycle clear
        stat_next[`ST_OPP] = stat_next[`ST_OPP] || opp_evt;
        stat_next[`ST_OCP] = stat_next[`ST_OCP] || ocp_evt;
        stat_next[`ST_SCP] = stat_next[`ST_SCP] || scp_evt;
        stat_next[`ST_CMR] = stat_next[`ST_CMR] || cmr_evt;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            ctrl_reg    <= `CTRL_RST;
            filt_reg    <= `OPP_FILT_RST;
            sc_cfg_reg  <= `SC_CFG_RST;
            restart_reg <= `RESTART_RST;
            mask_reg    <= '0;
            stat_reg    <= '0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= '0;
        end else begin
            ctrl_reg    <= ctrl_next;
            filt_reg    <= filt_next;
            sc_cfg_reg  <= sc_cfg_next;
            restart_reg <= restart_next;
            mask_reg    <= mask_next;
            stat_reg    <= stat_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg  <= prdata_next;
        end
    end

    assign o_prdata         = prdata_reg;
    assign o_pready         = pready_reg;
    assign o_pslverr        = pslverr_reg;
    assign o_switch_en      = sw_en_reg;
    assign o_hs_off         = hs_off_reg;
    assign o_ls_off         = ls_off_reg;
    assign o_cmr_level      = ctrl_reg[`CTRL_CMR_LSB +: 3];
    assign o_xcap_discharge = xcap_reg;
    assign o_gpio           = gpio_reg;
    assign o_irq            = irq_reg;

    // checks on the protection behaviour
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);

    opp_cause_a: assert property (opp_evt |-> fb_low_s && $past(fb_low_s))
        else $error("overpower fault without sustained low feedback");
    ocp_halt_a: assert property (ocp_evt |=> !o_switch_en)
        else $error("switching not halted after overcurrent");
    sc_incr_a: assert property (ocp_evt && !scp_evt && sc_cnt_reg != 8'hff
                                |=> sc_cnt_reg == $past(sc_cnt_reg) + 8'h01)
        else $error("short-circuit counter missed an overcurrent");
    sc_clear_a: assert property (i_cycle_end && !ocp_cyc_reg && !ocp_evt
                                 && (clean_reg + 8'h01) >= sc_cfg_reg[15:8]
                                 |=> sc_cnt_reg == 8'h00)
        else $error("short-circuit counter not cleared after clean cycles");
    scp_trip_a: assert property (sc_cnt_reg > sc_cfg_reg[7:0]
                                 |=> stat_reg[`ST_SCP] ##1 !o_switch_en)
        else $error("short-circuit trip not flagged or switching kept");
    cmr_off_a: assert property (i_hs_on && cmr_pos_s |=> o_hs_off)
        else $error("high side not turned off near zero current");
    xcap_gate_a: assert property (o_xcap_discharge |-> $past(!ac_s && ctrl_reg[0]))
        else $error("discharge active with mains present or disabled");
    xcap_off_a: assert property (!ctrl_reg[0] |=> !o_xcap_discharge)
        else $error("discharge active while disabled");
    gpio_norm_a: assert property (i_ctrl_mode != llc_prot_pkg::MODE_BURST |=> !o_gpio)
        else $error("standby output high outside burst mode");
    gpio_burst_a: assert property (i_ctrl_mode == llc_prot_pkg::MODE_BURST
                                   |=> o_gpio == $past(i_burst_off))
        else $error("standby output does not follow burst-off");
    latch_hold_a: assert property (latched[1] |=> latched[1] && !o_switch_en)
        else $error("latched short circuit released or switching");
    retry_free_a: assert property (ctrl_reg[2:1] == 2'h0 && !latched[0]
                                   |=> !latched[0])
        else $error("retry response latched");
    filt_restart_a: assert property (!fb_low_s |=> opp_cnt_reg == 16'h0000)
        else $error("overpower timer kept counting after recovery");
    stat_sticky_a: assert property (ocp_evt |=> stat_reg[`ST_OCP])
        else $error("overcurrent not flagged");

    opp_seen_c: cover property (opp_evt);
    scp_seen_c: cover property (scp_evt ##[1:100] o_switch_en);
    burst_off_c: cover property (o_gpio ##1 !o_gpio);
    cmr_ls_c: cover property (o_ls_off);

endmodule

// File: llc_far_model.sv
// far-side model: half-bridge driver phases and switching-cycle end pulses
`timescale 1ns/100ps

module llc_far_model (
    input  wire logic i_core_clk,
    input  wire logic i_resetn,
    output logic      o_cycle_end,
    output logic      o_hs_on,
    output logic      o_ls_on
);
    logic [2:0] phase_reg;
    logic [2:0] phase_next;

    // eight-clock switching cycle, high side first half
    always_comb begin
        phase_next = phase_reg + 3'h1;
    end

    // phase counter; held at zero in reset so no pulse leaks out early
    always_ff @(posedge i_core_clk) begin
        if (!i_resetn) begin
            phase_reg <= 3'h0;
        end else begin
            phase_reg <= phase_next;
        end
    end

    // both sides never conduct together
    assign o_hs_on     = ~phase_reg[2];
    assign o_ls_on     = phase_reg[2];
    assign o_cycle_end = &phase_reg;
endmodule

// File: tb_llc_protection_supervisor.sv
// self-checking bench of the protection supervisor over its register bus
`timescale 1ns/100ps
`include "llc_prot_consts.svh"

module tb_llc_protection_supervisor;
    logic        clk;
    logic        rstn;
    logic        psel;
    logic        pen;
    logic        pwr;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        perr;
    logic        fb_low;
    logic        cs_over;
    logic        pos_x;
    logic        ac;
    logic        cyc_end;
    logic        hs_on;
    logic        ls_on;
    logic [1:0]  mode;
    logic        boff;
    logic        sw_en;
    logic        hs_off;
    logic        xcap;
    logic        gpio;
    logic        irq;
    logic [31:0] rd;
    logic        er;
    logic        hs_off_seen;
    int          err_count;
    int          checked;
    int          cycles;

    llc_far_model FAR (.i_core_clk(clk), .i_resetn(rstn), .o_cycle_end(cyc_end),
        .o_hs_on(hs_on), .o_ls_on(ls_on));

    llc_protection_supervisor DUT (.i_core_clk(clk), .i_resetn(rstn), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(perr), .i_fb_low(fb_low),
        .i_cs_over(cs_over), .i_cmr_pos_cross(pos_x), .i_cmr_neg_cross(1'b0),
        .i_ac_present(ac), .i_cycle_end(cyc_end), .i_hs_on(hs_on), .i_ls_on(ls_on),
        .i_ctrl_mode(llc_prot_pkg::ctrl_mode_t'(mode)), .i_burst_off(boff),
        .o_switch_en(sw_en), .o_hs_off(hs_off), .o_ls_off(), .o_cmr_level(),
        .o_xcap_discharge(xcap), .o_gpio(gpio), .o_irq(irq));

    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // hang guard and turn-off request monitor
    always @(posedge clk) begin
        cycles++;
        if (hs_off === 1'b1) hs_off_seen = 1'b1;
        if (cycles == 20000) begin
            err_count++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge clk);
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    // overcurrent inside one switching cycle; a pulse across a cycle end would count twice
    task automatic overcurrent_fault();
        do @(posedge clk); while (cyc_end !== 1'b1);
        cs_over <= 1'b1;
        waitc(3);
        cs_over <= 1'b0;
        waitc(2);
        chk("switch_en", 32'h0, {31'h0, sw_en});
        waitc(12);
    endtask

    initial begin
        {clk, psel, pen, pwr, fb_low, cs_over, pos_x, boff, hs_off_seen} = '0;
        {paddr, pwdata, mode, err_count, checked, cycles} = '0;
        rstn = 1'b0;
        ac = 1'b1;
        waitc(6);
        rstn <= 1'b1;
        apb(0, `ADDR_CTRL, 0);
        chk("ctrl", 32'h21, rd);
        apb(0, `ADDR_SC_CFG, 0);
        chk("sc_cfg", 32'h1008, rd);
        apb(0, 8'h1c, 0);
        chk("unmapped", 32'h1, {31'h0, er});
        apb(1, `ADDR_MASK, 32'hf);
        apb(1, `ADDR_RESTART, 32'h2);
        apb(1, `ADDR_OPP_FILT, 32'h2);
        apb(1, `ADDR_SC_CFG, 32'hff01);
        overcurrent_fault();
        chk("irq", 32'h1, {31'h0, irq});
        apb(0, `ADDR_STATE, 0);
        chk("sc_count", 32'h1, {24'h0, rd[7:0]});
        overcurrent_fault();
        apb(0, `ADDR_STATUS, 0);
        chk("status_sc", 32'h6, rd & 32'h6);
        waitc(150);
        chk("retry", 32'h1, {31'h0, sw_en});
        apb(1, `ADDR_STATUS, 32'hf);
        waitc(3);
        chk("irq_clr", 32'h0, {31'h0, irq});
        // clean cycles clear the event counter
        apb(1, `ADDR_SC_CFG, 32'h0201);
        overcurrent_fault();
        waitc(20);
        apb(0, `ADDR_STATE, 0);
        chk("sc_cleared", 32'h0, {24'h0, rd[7:0]});
        apb(1, `ADDR_SC_CFG, 32'hff01);
        // overpower: two short dips, then a long one
        for (int i = 0; i < 3; i++) begin
            fb_low <= 1'b1;
            waitc(i == 2 ? 120 : 30);
            fb_low <= 1'b0;
            waitc(4);
            apb(0, `ADDR_STATUS, 0);
            chk("status_opp", {31'h0, i == 2}, rd & 32'h1);
        end
        waitc(150);
        pos_x <= 1'b1;
        waitc(20);
        pos_x <= 1'b0;
        chk("hs_off", 32'h1, {31'h0, hs_off_seen});
        ac <= 1'b0;
        waitc(5);
        chk("xcap_on", 32'h1, {31'h0, xcap});
        apb(1, `ADDR_CTRL, 32'h30);
        waitc(3);
        chk("xcap_off", 32'h0, {31'h0, xcap});
        for (int m = 0; m < 8; m++) begin
            mode <= m[1:0];
            boff <= m[2];
            waitc(4);
            chk("gpio", {31'h0, m == 7}, {31'h0, gpio});
        end
        overcurrent_fault();
        overcurrent_fault();
        waitc(300);
        chk("latched", 32'h0, {31'h0, sw_en});
        test_done();
    end
endmodule
